// *** ddac_params.svh ***
// Constants of the dual 8-bit converter control block.
// Assumes a 10 MHz mclk and the byte-wide register port of ddac_top.
`ifndef DDAC_PARAMS_SVH
`define DDAC_PARAMS_SVH

// Register addresses
`define DDAC_ADDR_CODE0     32'hfffe6800
`define DDAC_ADDR_CODE1     32'hfffe6801
`define DDAC_ADDR_CONTROL   32'hfffe6802

// Reset values
`define DDAC_CODE_RESET     8'h00
`define DDAC_CTRL_RESET     8'h1f
`define DDAC_RSVD_ONES      5'h1f

// Control field positions
`define DDAC_BIT_OE1        7
`define DDAC_BIT_OE0        6
`define DDAC_BIT_JOINT      5

// Conversion time: longest time, rounded down to whole cycles
`define DDAC_CONV_TIME_NS   10000
`define DDAC_CLK_PERIOD_NS  100
`define DDAC_CONV_CYCLES    (`DDAC_CONV_TIME_NS / `DDAC_CLK_PERIOD_NS)
`define DDAC_CNT_W          7

`endif

// *** ddac_pkg.sv ***
// Types shared by the converter control modules.
// Assumes ddac_params.svh for all numeric constants but the channel count.
package ddac_pkg;

    // Conversion path states
    typedef enum logic [1:0] {
        PATH_IDLE,
        PATH_CONV,
        PATH_HOLD
    } ddac_path_state_type;

    // Channel count
    localparam int DDAC_CHANNELS = 2;

endpackage

// *** ddac_chan_if.sv ***
// Signals between the register side and one conversion path.
// Assumes one instance per channel, all on mclk.
`timescale 1ns/100ps
interface ddac_chan_if;
    logic       start;      // One-cycle conversion start
    logic       enable;     // Channel conversion enabled
    logic [7:0] code;       // Code to convert
    logic [7:0] held_code;  // Code presented to analog core
    logic       busy;       // Conversion in progress
    logic       settled;    // Result settled; valid on the pin only while driven

    modport ctl  (output start, enable, code, input held_code, busy, settled);
    modport path (input start, enable, code, output held_code, busy, settled);
endinterface

// *** ddac_chan.sv ***
// One independent conversion path: latches a code and times settling.
// Assumes start is a one-cycle pulse from ddac_top on mclk.
`timescale 1ns/100ps
`include "ddac_params.svh"
module ddac_chan
    import ddac_pkg::*;
(
    // Clock and reset
    input wire logic  mclk,
    input wire logic  nrst,
    // Register side
    ddac_chan_if.path chan
);

    ddac_path_state_type         state;
    logic [`DDAC_CNT_W-1:0]      cnt;

    // RQ11: path state and timing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= PATH_IDLE;
            cnt   <= '0;
        end else if (!chan.enable) begin
            state <= PATH_IDLE;
            cnt   <= '0;
        end else if (chan.start) begin
            state <= PATH_CONV;
            cnt   <= `DDAC_CNT_W'(`DDAC_CONV_CYCLES);
        end else begin
            unique case (state)
                PATH_IDLE: state <= PATH_IDLE;
                PATH_CONV: begin
                    cnt <= cnt - `DDAC_CNT_W'(1);
                    if (cnt == `DDAC_CNT_W'(1)) begin
                        state <= PATH_HOLD;
                    end
                end
                PATH_HOLD: state <= PATH_HOLD;
            endcase
        end
    end

    // RQ21: code latched at each start
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            chan.held_code <= `DDAC_CODE_RESET;
        end else if (chan.start) begin
            chan.held_code <= chan.code;
        end
    end

    assign chan.busy    = (state == PATH_CONV);
    assign chan.settled = (state == PATH_HOLD);

    // RQ19: settling after exactly the conversion time
    settle_on_time_a : assert property (@(posedge mclk) disable iff (!nrst) // RQ19
        $rose(chan.settled) |-> $past(cnt) == `DDAC_CNT_W'(1) && $past(chan.busy))
        else $error("result settled off schedule");
    // RQ12: result stays until restart or disable
    result_holds_a : assert property (@(posedge mclk) disable iff (!nrst) // RQ12
        chan.settled && chan.enable && !chan.start |=> chan.settled)
        else $error("settled result dropped early");

endmodule // ddac_chan

// *** ddac_top.sv ***
// Control logic of a two-channel 8-bit converter: registers, channel
// enables, restart on rewrite and standby handling.
// Assumes the bus master, standby controls and analog core share mclk.
`timescale 1ns/100ps
`include "ddac_params.svh"

// Contract
// RQ1: Each channel has an 8-bit read/write code register it converts.
// RQ2: Code registers clear on reset, deep standby and module standby.
// RQ3: Control register resets to 1f under the same conditions.
// RQ4: Control bit 7 enables channel 1 conversion and output.
// RQ5: Control bit 6 enables channel 0 conversion and output.
// RQ6: Control bit 5 selects independent or joint conversion.
// RQ7: Control bits 4..0 read as one and ignore writes.
// RQ8: Joint bit low: each channel converts only when its enable is set.
// RQ9: Joint bit and channel 0 enable set: both channels convert.
// RQ10: Pin drive follows only the channel's own output enable.
// RQ11: Two conversion paths operate independently.
// RQ12: Result appears after conversion time, held until rewrite or disable.
// RQ13: Writing an enabled channel's code restarts its conversion.
// RQ14: Clearing an output enable stops that channel's output.
// RQ15: Starts in module standby; registers usable only after it ends.
// RQ16: Software standby keeps the outputs at their current values.
// RQ17: Deep standby stops conversion and both outputs.
// RQ18: Software clears all enables before deep standby; t_deep enters it with channel 0 still enabled.
// RQ19: Conversion completes within ten microseconds.
// RQ20: Joint bit with channel 1 enable alone converts both channels.
// RQ21: Each channel gives the core its code and a start strobe.
module ddac_top
    import ddac_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // Register port
    input  wire logic [31:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Standby controls
    input  wire logic        mod_standby,
    input  wire logic        sw_standby,
    input  wire logic        deep_standby,
    // Channel 0 to analog core
    output logic      [7:0]  analog_out_ch0_code,
    output logic             analog_out_ch0_start,
    output logic             analog_out_ch0_drive,
    output logic             analog_out_ch0_valid,
    // Channel 1 to analog core
    output logic      [7:0]  analog_out_ch1_code,
    output logic             analog_out_ch1_start,
    output logic             analog_out_ch1_drive,
    output logic             analog_out_ch1_valid
);

    // Control register fields
    logic       out_enable_ch0;
    logic       out_enable_ch1;
    logic       joint_conv_enable;

    // Per-channel state
    logic [7:0] channel_code_reg [DDAC_CHANNELS];
    logic [DDAC_CHANNELS-1:0] out_en;
    logic [DDAC_CHANNELS-1:0] conv_en;
    logic [DDAC_CHANNELS-1:0] conv_en_q;
    logic [DDAC_CHANNELS-1:0] wr_code;
    logic [DDAC_CHANNELS-1:0] conv_start;
    logic [DDAC_CHANNELS-1:0] drive;
    logic [DDAC_CHANNELS-1:0] settled;

    // Access and standby qualifiers
    logic       halted;
    logic       access_ok;
    logic       wr_ctrl;
    logic [7:0] ctrl_value;
    logic [7:0] next_rdata;

    // Control reset value, split into its fields below
    localparam logic [7:0] CTRL_INIT = `DDAC_CTRL_RESET;

    ddac_chan_if chan_if [DDAC_CHANNELS] ();

    // RQ15: registers frozen and held at reset while halted
    assign halted    = mod_standby | deep_standby;
    assign access_ok = !halted;

    // Write decode for the control register
    assign wr_ctrl = reg_wr && access_ok && (reg_addr == `DDAC_ADDR_CONTROL);

    // RQ7: reserved bits fixed at one
    assign ctrl_value = {out_enable_ch1, out_enable_ch0, joint_conv_enable,
                         `DDAC_RSVD_ONES};

    // RQ3: control register with standby clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            out_enable_ch1    <= CTRL_INIT[`DDAC_BIT_OE1];
            out_enable_ch0    <= CTRL_INIT[`DDAC_BIT_OE0];
            joint_conv_enable <= CTRL_INIT[`DDAC_BIT_JOINT];
        end else if (halted) begin
            out_enable_ch1    <= CTRL_INIT[`DDAC_BIT_OE1];
            out_enable_ch0    <= CTRL_INIT[`DDAC_BIT_OE0];
            joint_conv_enable <= CTRL_INIT[`DDAC_BIT_JOINT];
        end else if (wr_ctrl) begin
            // RQ4: channel 1 enable
            out_enable_ch1    <= reg_wdata[`DDAC_BIT_OE1];
            // RQ5: channel 0 enable
            out_enable_ch0    <= reg_wdata[`DDAC_BIT_OE0];
            // RQ6: joint conversion select
            joint_conv_enable <= reg_wdata[`DDAC_BIT_JOINT];
        end
    end

    assign out_en = {out_enable_ch1, out_enable_ch0};

    // RQ8: independent mode follows each enable
    // RQ9: joint mode converts both when channel 0 is on
    // RQ20: joint with channel 1 alone treated as both
    assign conv_en[0] = out_enable_ch0 | (joint_conv_enable & out_enable_ch1);
    assign conv_en[1] = out_enable_ch1 | (joint_conv_enable & out_enable_ch0);

    // Per-channel registers, starts and path instances
    for (genvar i = 0; i < DDAC_CHANNELS; i++) begin : g_chan

        assign wr_code[i] = reg_wr && access_ok &&
                            (reg_addr == (`DDAC_ADDR_CODE0 + 32'(i)));

        // RQ1: code register
        // RQ2: cleared in deep or module standby
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                channel_code_reg[i] <= `DDAC_CODE_RESET;
            end else if (halted) begin
                channel_code_reg[i] <= `DDAC_CODE_RESET;
            end else if (wr_code[i]) begin
                channel_code_reg[i] <= reg_wdata;
            end
        end

        // Previous enable, for start on enable
        always_ff @(posedge mclk or negedge nrst) begin
            if (!nrst) begin
                conv_en_q[i] <= 1'b0;
            end else begin
                conv_en_q[i] <= conv_en[i];
            end
        end

        // RQ13: restart on rewrite or new enable
        // RQ16: no restart in software standby, outputs held
        assign conv_start[i] = conv_en[i] && !sw_standby &&
                               (wr_code[i] || !conv_en_q[i]);

        // RQ10: drive from own enable only
        // RQ14: cleared enable stops the output
        // RQ17: deep standby stops the output
        assign drive[i] = out_en[i] && !halted;

        // RQ21: code and strobe to the path
        assign chan_if[i].start  = conv_start[i];
        assign chan_if[i].enable = conv_en[i] && !halted;
        assign chan_if[i].code   = wr_code[i] ? reg_wdata : channel_code_reg[i];
        assign settled[i]        = chan_if[i].settled;

        // RQ11: one independent path per channel
        ddac_chan u_path (
            .mclk (mclk),
            .nrst (nrst),
            .chan (chan_if[i])
        );
    end

    // Pin-side outputs
    assign analog_out_ch0_code  = chan_if[0].held_code;
    assign analog_out_ch0_start = conv_start[0];
    assign analog_out_ch0_drive = drive[0];
    assign analog_out_ch0_valid = settled[0] && drive[0];
    assign analog_out_ch1_code  = chan_if[1].held_code;
    assign analog_out_ch1_start = conv_start[1];
    assign analog_out_ch1_drive = drive[1];
    assign analog_out_ch1_valid = settled[1] && drive[1];

    // Read mux, unmapped or halted reads give zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd && access_ok) begin
            unique case (reg_addr)
                `DDAC_ADDR_CODE0:   next_rdata = channel_code_reg[0];
                `DDAC_ADDR_CODE1:   next_rdata = channel_code_reg[1];
                `DDAC_ADDR_CONTROL: next_rdata = ctrl_value;
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    // Read data for exactly one cycle after the strobe
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    // RQ1: written code is stored
    code_write_a : assert property ( // RQ1
        wr_code[0] |=> channel_code_reg[0] == $past(reg_wdata))
        else $error("code write not stored");

    // RQ2: standby clears codes
    code_clear_a : assert property ( // RQ2
        halted |=> channel_code_reg[0] == `DDAC_CODE_RESET &&
                   channel_code_reg[1] == `DDAC_CODE_RESET)
        else $error("code not cleared in standby");

    // RQ3: standby restores control reset value
    ctrl_reset_a : assert property ( // RQ3
        halted |=> ctrl_value == `DDAC_CTRL_RESET)
        else $error("control not reset in standby");

    // RQ7: reserved bits read one
    rsvd_read_a : assert property ( // RQ7
        reg_rd && access_ok && reg_addr == `DDAC_ADDR_CONTROL
        |=> reg_rdata[4:0] == `DDAC_RSVD_ONES)
        else $error("reserved bits not read as one");

    // RQ8: independent conversion
    indep_conv_a : assert property ( // RQ8
        !joint_conv_enable |-> conv_en == out_en)
        else $error("independent mode enable mismatch");

    // RQ9: joint conversion of both channels
    joint_conv_a : assert property ( // RQ9
        joint_conv_enable && (out_enable_ch0 || out_enable_ch1) |-> &conv_en)
        else $error("joint mode did not enable both");

    // RQ14: cleared enable stops the pin
    drive_stop_a : assert property ( // RQ14
        wr_ctrl && !reg_wdata[`DDAC_BIT_OE1] |=> !analog_out_ch1_drive)
        else $error("channel 1 still driven after disable");

    // RQ13: rewrite restarts conversion
    restart_write_a : assert property ( // RQ13
        wr_code[0] && conv_en[0] && !sw_standby
        |-> analog_out_ch0_start ##1 !analog_out_ch0_valid)
        else $error("rewrite did not restart channel 0");

    // RQ16: software standby holds output
    sw_hold_a : assert property ( // RQ16
        sw_standby && !halted && $past(sw_standby)
        |-> $stable(analog_out_ch0_code) && $stable(analog_out_ch1_code))
        else $error("output changed in software standby");

    // RQ17: deep standby stops both outputs
    deep_stop_a : assert property ( // RQ17
        deep_standby |-> !analog_out_ch0_drive && !analog_out_ch1_drive
        ##1 !analog_out_ch0_valid && !analog_out_ch1_valid)
        else $error("output driven in deep standby");

    // RQ15: no register access while halted
    stby_access_a : assert property ( // RQ15
        reg_rd && mod_standby |=> reg_rdata == 8'h00)
        else $error("register read while halted");

    // RQ1: second code register stored
    code_write1_a : assert property ( // RQ1
        wr_code[1] |=> channel_code_reg[1] == $past(reg_wdata))
        else $error("channel 1 code write not stored");

    // RQ1: code register reads back
    code_read1_a : assert property ( // RQ1
        reg_rd && access_ok && reg_addr == `DDAC_ADDR_CODE1
        |=> reg_rdata == $past(channel_code_reg[1]))
        else $error("channel 1 code read mismatch");

    // RQ4: channel 1 enable written
    en1_write_a : assert property ( // RQ4
        wr_ctrl |=> out_enable_ch1 == $past(reg_wdata[`DDAC_BIT_OE1]))
        else $error("channel 1 enable not written");

    // RQ5: channel 0 enable written
    en0_write_a : assert property ( // RQ5
        wr_ctrl |=> out_enable_ch0 == $past(reg_wdata[`DDAC_BIT_OE0]))
        else $error("channel 0 enable not written");

    // RQ6: joint select written
    joint_write_a : assert property ( // RQ6
        wr_ctrl |=> joint_conv_enable == $past(reg_wdata[`DDAC_BIT_JOINT]))
        else $error("joint select not written");

    // RQ9: no enable, no conversion
    no_conv_a : assert property ( // RQ9
        !out_enable_ch0 && !out_enable_ch1 |-> conv_en == 2'b00)
        else $error("conversion without any enable");

    // RQ20: joint with channel 1 converts both
    joint_ch1_a : assert property ( // RQ20
        joint_conv_enable && out_enable_ch1 |-> &conv_en)
        else $error("joint mode with channel 1 not both");

    // RQ10: joint bit never drives a pin
    drive_own_a : assert property ( // RQ10
        !out_enable_ch1 |-> !analog_out_ch1_drive && !analog_out_ch1_valid)
        else $error("channel 1 driven without its enable");

    // RQ14: cleared channel 0 enable stops the pin
    drive_stop0_a : assert property ( // RQ14
        wr_ctrl && !reg_wdata[`DDAC_BIT_OE0] |=> !analog_out_ch0_drive)
        else $error("channel 0 still driven after disable");

    // RQ13: rewrite restarts channel 1
    restart_ch1_a : assert property ( // RQ13
        wr_code[1] && conv_en[1] && !sw_standby
        |-> analog_out_ch1_start ##1 !analog_out_ch1_valid)
        else $error("rewrite did not restart channel 1");

    // RQ12: settled result stays driven
    hold_valid0_a : assert property ( // RQ12
        analog_out_ch0_valid && !analog_out_ch0_start && !wr_ctrl
        |=> analog_out_ch0_valid || halted)
        else $error("channel 0 result dropped early");

    // RQ16: no new start in software standby
    sw_no_start_a : assert property ( // RQ16
        sw_standby |-> !analog_out_ch0_start && !analog_out_ch1_start)
        else $error("conversion started in software standby");

    // RQ15: no write taken while halted
    stby_write_a : assert property ( // RQ15
        mod_standby |-> !wr_ctrl && wr_code == 2'b00)
        else $error("register write taken while halted");

    // RQ21: written code reaches the core with its strobe
    strobe_code_a : assert property ( // RQ21
        wr_code[0] && analog_out_ch0_start |=> analog_out_ch0_code == $past(reg_wdata))
        else $error("channel 0 code not latched at start");

    // Main scenarios
    conv_done_c : cover property (
        analog_out_ch0_start ##[1:200] analog_out_ch0_valid);
    joint_both_c : cover property (
        joint_conv_enable && out_enable_ch0 && !out_enable_ch1 &&
        analog_out_ch1_start);
    restart_c : cover property (
        analog_out_ch1_valid ##1 wr_code[1] ##[1:200] analog_out_ch1_valid);
    sw_hold_c : cover property (
        analog_out_ch0_valid && sw_standby [*4]);
    rewrite0_c : cover property (
        analog_out_ch0_valid ##1 analog_out_ch0_start);

endmodule // ddac_top

// *** ddac_core_model.sv ***
// Behavioural analog core for one converter channel.
// Assumes the code, drive and valid outputs of ddac_top on mclk.
`timescale 1ns/100ps
module ddac_core_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       nrst,
    // Channel from the control block
    input  wire logic [7:0] code,
    input  wire logic       drive,
    input  wire logic       valid,
    // Output pin level
    output logic      [7:0] pin
);
    // pin follows settled code only while driven
    // code taken as presented with its start
    // A released pin flips every cycle so a stale value never holds for two cycles
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin <= 8'h00;
        end else if (drive && valid) begin
            pin <= code;
        end else begin
            pin <= ~pin;
        end
    end
endmodule // ddac_core_model

// *** dual_dac_control_test.sv ***
// Self-checking bench for the dual converter control block.
// Assumes ddac_top on a 10 MHz mclk, one core model per channel.
`timescale 1ns/100ps
`include "ddac_params.svh"
module dual_dac_control_test
    import ddac_pkg::*;
;
    logic        mclk, nrst, reg_wr, reg_rd;
    logic        mod_standby, sw_standby, deep_standby;
    logic [31:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata;
    logic [7:0]  code_o [2];
    logic [7:0]  pins [2];
    logic [1:0]  st_v, drv_v, vld_v, prev_v;
    int          miscompares, cmp_count, cyc;
    int          st_cnt [2];
    int          st_cyc [2];
    int          lat [2];

    ddac_top u_ddac_top (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mod_standby(mod_standby), .sw_standby(sw_standby),
        .deep_standby(deep_standby),
        .analog_out_ch0_code(code_o[0]), .analog_out_ch0_start(st_v[0]),
        .analog_out_ch0_drive(drv_v[0]), .analog_out_ch0_valid(vld_v[0]),
        .analog_out_ch1_code(code_o[1]), .analog_out_ch1_start(st_v[1]),
        .analog_out_ch1_drive(drv_v[1]), .analog_out_ch1_valid(vld_v[1])
    );
    ddac_core_model u_ddac_core_model0 (.mclk(mclk), .nrst(nrst), .code(code_o[0]),
        .drive(drv_v[0]), .valid(vld_v[0]), .pin(pins[0]));
    ddac_core_model u_ddac_core_model1 (.mclk(mclk), .nrst(nrst), .code(code_o[1]),
        .drive(drv_v[1]), .valid(vld_v[1]), .pin(pins[1]));

    // Clock generator
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Start counts, settle latency in sampled edges, and the hang limit
    always @(posedge mclk) begin
        cyc++;
        for (int c = 0; c < 2; c++) begin
            if (st_v[c] === 1'b1) begin
                st_cnt[c]++;
                st_cyc[c] = cyc;
            end
            if (vld_v[c] === 1'b1 && prev_v[c] !== 1'b1)
                lat[c] = cyc - st_cyc[c];
        end
        prev_v = vld_v;
        if (cyc == 8000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_sig(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t signal got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [31:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 check_rd(reg_rdata, exp);
    endtask

    // Wait out one conversion, then check start count, latency and pin
    task automatic settle(input int c, input int n, input logic [7:0] v);
        repeat (104) @(posedge mclk);
        #1 check_sig(st_cnt[c], n + 1);
        check_sig(lat[c], `DDAC_CONV_CYCLES + 1);
        check_sig(vld_v[c], 1'b1);
        check_sig(pins[c], v);
    endtask

    // Halted until module standby ends, then reset values and unmapped place
    task automatic t_standby_reset();
        reg_write(`DDAC_ADDR_CONTROL, 8'h40);
        reg_read(`DDAC_ADDR_CONTROL, 8'h00);
        @(posedge mclk);
        mod_standby <= 1'b0;
        reg_read(`DDAC_ADDR_CONTROL, `DDAC_CTRL_RESET);
        reg_read(`DDAC_ADDR_CODE0, `DDAC_CODE_RESET);
        reg_read(`DDAC_ADDR_CODE1, `DDAC_CODE_RESET);
        reg_read(32'hfffe6803, 8'h00);
        check_sig(st_cnt[0] + st_cnt[1], 0);
    endtask

    // Code registers read back; reserved control bits stay one
    task automatic t_regs();
        reg_write(`DDAC_ADDR_CODE0, 8'ha5);
        reg_write(`DDAC_ADDR_CODE1, 8'h5a);
        reg_write(`DDAC_ADDR_CONTROL, 8'h00);
        reg_read(`DDAC_ADDR_CODE0, 8'ha5);
        reg_read(`DDAC_ADDR_CODE1, 8'h5a);
        reg_read(`DDAC_ADDR_CONTROL, 8'h1f);
    endtask

    // One channel alone: convert, settle, then disable
    task automatic t_single(input int c, input logic [7:0] v);
        int n;
        reg_write(c ? `DDAC_ADDR_CODE1 : `DDAC_ADDR_CODE0, v);
        n = st_cnt[c];
        reg_write(`DDAC_ADDR_CONTROL, c ? 8'h80 : 8'h40);
        settle(c, n, v);
        check_sig(drv_v[1-c], 1'b0);
        reg_write(`DDAC_ADDR_CONTROL, 8'h00);
        @(posedge mclk);
        #1 check_sig({drv_v[c], vld_v[c]}, 2'b00);
    endtask

    // Rewriting an enabled code restarts its conversion at once
    task automatic t_rewrite();
        int n;
        reg_write(`DDAC_ADDR_CONTROL, 8'h40);
        settle(0, st_cnt[0], 8'ha5);
        n = st_cnt[0];
        reg_write(`DDAC_ADDR_CODE0, 8'h77);
        #1 check_sig(vld_v[0], 1'b0);
        settle(0, n, 8'h77);
    endtask

    // Every enable combination: starts per channel and pin drive
    task automatic t_joint();
        logic [15:0] tbl;
        int          n0, n1;
        tbl = 16'b11_11_11_00_11_10_01_00;
        for (int i = 0; i < 8; i++) begin
            reg_write(`DDAC_ADDR_CONTROL, 8'h00);
            n0 = st_cnt[0];
            n1 = st_cnt[1];
            reg_write(`DDAC_ADDR_CONTROL, {i[1], i[0], i[2], 5'h00});
            @(posedge mclk);
            #1 check_sig(st_cnt[0] - n0, tbl[2*i]);
            check_sig(st_cnt[1] - n1, tbl[2*i+1]);
            check_sig(drv_v, i[1:0]);
        end
        reg_write(`DDAC_ADDR_CONTROL, 8'h00);
    endtask

    // Software standby keeps the output and blocks new starts
    task automatic t_sw_standby();
        int n;
        reg_write(`DDAC_ADDR_CODE0, 8'h3c);
        reg_write(`DDAC_ADDR_CONTROL, 8'h40);
        settle(0, st_cnt[0], 8'h3c);
        @(posedge mclk);
        sw_standby <= 1'b1;
        n = st_cnt[0];
        reg_write(`DDAC_ADDR_CODE0, 8'hc3);
        repeat (5) @(posedge mclk);
        #1 check_sig(st_cnt[0], n);
        check_sig({vld_v[0], pins[0]}, {1'b1, 8'h3c});
        reg_read(`DDAC_ADDR_CODE0, 8'hc3);
        @(posedge mclk);
        sw_standby <= 1'b0;
    endtask

    // Deep standby stops the outputs and resets the registers
    task automatic t_deep();
        @(posedge mclk);
        deep_standby <= 1'b1;
        #1 check_sig(drv_v, 2'b00);
        repeat (2) @(posedge mclk);
        #1 check_sig(vld_v, 2'b00);
        @(posedge mclk);
        deep_standby <= 1'b0;
        reg_read(`DDAC_ADDR_CONTROL, `DDAC_CTRL_RESET);
        reg_read(`DDAC_ADDR_CODE0, `DDAC_CODE_RESET);
    endtask

    // Main sequence: module standby held from reset, then the scenarios
    initial begin
        nrst = 1'b0;
        reg_addr = 32'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mod_standby = 1'b1;
        sw_standby = 1'b0;
        deep_standby = 1'b0;
        prev_v = 2'b00;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        t_standby_reset();
        t_regs();
        t_single(0, 8'ha5);
        t_single(1, 8'h5a);
        t_rewrite();
        t_joint();
        t_sw_standby();
        t_deep();
        finish_test();
    end
endmodule // dual_dac_control_test
